// *** include/ffc_pkg.sv ***
`default_nettype none
package ffc_pkg;
	// Pixel scale
	localparam int          PIX_W   = 12;
	localparam logic [11:0] PIX_MAX = 12'hfff;
	localparam logic [11:0] TGT_RST = 12'h800;
	localparam int          MAX_SLOTS = 32;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TGT  = 8'h04;
	localparam logic [7:0] A_CMD  = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0c;
	// Control fields
	localparam int CTRL_EN   = 0;
	localparam int CTRL_MAN  = 1;
	localparam int CTRL_FMT8 = 2;
	localparam int CTRL_SLOT = 4;
	localparam int SLOT_FW   = 5;
	// Command bits, write one to start
	localparam int CMD_BUILD = 0;
	localparam int CMD_STORE = 1;
	localparam int CMD_FETCH = 2;
	// Status fields
	localparam int ST_BUSY  = 0;
	localparam int ST_VALID = 1;
	localparam int ST_AUTO  = 16;
	// Pixel beat on both streams
	typedef struct packed {
		logic             sof;
		logic             sol;
		logic [PIX_W-1:0] data;
	} ffc_pix_t;
	typedef enum logic [2:0] {S_IDLE, S_ARM, S_BUILD, S_STORE, S_FETCH} ffc_state_t;
endpackage
`default_nettype wire

// *** hdl/ffc_top.sv ***
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ffc_top #(
	parameter int LINE_W = 512,
	parameter int DEC    = 16,
	parameter int SLOTS  = 16
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire ffc_pkg::ffc_pix_t in_pix,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output ffc_pkg::ffc_pix_t     out_pix
);
	// Derived sizes
	localparam int NPTS = LINE_W / DEC;
	localparam int CW   = $clog2(LINE_W);
	localparam int SH   = $clog2(DEC);
	localparam int PW   = $clog2(NPTS);
	localparam int SW   = $clog2(SLOTS);
	localparam int IW   = ffc_pkg::PIX_W + SH + 1;
	localparam int TW   = ffc_pkg::PIX_W + CW;

	// Refuse shapes the indexing cannot serve
	if ((1 << CW) != LINE_W || (1 << SH) != DEC || DEC < 2 || NPTS < 2
		|| (1 << SW) != SLOTS || SLOTS > ffc_pkg::MAX_SLOTS) begin : g_chk
		$error("ffc_top: bad LINE_W, DEC or SLOTS");
	end

	// Profile points and slot store, no reset by nature
	logic [11:0] prof [NPTS];
	logic [11:0] nvm [SLOTS*NPTS];

	// Control state and next values
	ffc_pkg::ffc_state_t state, next_state;
	logic [31:0]   ctrl, next_ctrl;
	logic [11:0]   tgt, next_tgt;
	logic [11:0]   auto_tgt, next_auto_tgt;
	logic          pvalid, next_pvalid;
	logic [PW-1:0] cnt, next_cnt;
	logic [SW-1:0] slot_l, next_slot_l;
	logic [CW-1:0] col, next_col;
	logic [11+SH:0] acc, next_acc;
	logic [TW-1:0] tot, next_tot;
	logic [31:0]   next_prdata;

	logic          prof_we, nvm_we;
	logic [PW-1:0] prof_wa;
	logic [11:0]   prof_wd;
	logic          push, pop, mapped, wr, building;
	logic [CW-1:0] cur_col;
	logic [PW-1:0] k, k1;
	logic [SH-1:0] f;
	logic [IW-1:0] isum;
	logic [11:0]   interp, target, corr, outv;
	logic [23:0]   prod, quot;
	ffc_pkg::ffc_pix_t res;

	// Address decode used by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		return a == ffc_pkg::A_CTRL || a == ffc_pkg::A_TGT
			|| a == ffc_pkg::A_CMD || a == ffc_pkg::A_STAT;
	endfunction

	// Bus handshake, zero wait states
	assign pready  = 1'b1;
	assign mapped  = is_mapped(paddr);
	assign pslverr = psel & penable & ~mapped;
	assign wr      = psel & penable & pwrite & mapped;
	assign push    = in_valid & in_ready;

	// Column position and interpolated profile level
	assign cur_col = in_pix.sol ? '0 : col;
	assign k       = cur_col[CW-1:SH];
	assign f       = cur_col[SH-1:0];
	assign k1      = (k == PW'(NPTS - 1)) ? k : k + 1'b1;
	assign isum    = IW'(prof[k]) * (IW'(DEC) - IW'(f)) + IW'(prof[k1]) * IW'(f);
	assign interp  = isum[ffc_pkg::PIX_W+SH-1:SH];

	// Divide by the profile, scale to target, clamp
	always_comb begin
		target = ctrl[ffc_pkg::CTRL_MAN] ? tgt : auto_tgt;
		prod   = 24'(in_pix.data) * 24'(target);
		quot   = (interp == '0) ? 24'hffffff : prod / 24'(interp);
		corr   = (|quot[23:12]) ? ffc_pkg::PIX_MAX : quot[11:0];
		outv   = (ctrl[ffc_pkg::CTRL_EN] && pvalid) ? corr : in_pix.data;
		res    = in_pix;
		res.data = ctrl[ffc_pkg::CTRL_FMT8] ? {4'h0, outv[11:4]} : outv;
	end

	// Control, commands and profile build
	always_comb begin
		next_state    = state;
		next_ctrl     = ctrl;
		next_tgt      = tgt;
		next_auto_tgt = auto_tgt;
		next_pvalid   = pvalid;
		next_cnt      = cnt;
		next_slot_l   = slot_l;
		next_col      = col;
		next_acc      = acc;
		next_tot      = tot;
		next_prdata   = 32'h0000_0000;
		prof_we       = 1'b0;
		prof_wa       = k;
		prof_wd       = 12'h000;
		nvm_we        = 1'b0;
		building      = (state == ffc_pkg::S_BUILD)
			|| (state == ffc_pkg::S_ARM && push && in_pix.sof);
		if (push) begin
			next_col = cur_col + 1'b1;
		end
		// Register read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			case (paddr)
				ffc_pkg::A_CTRL: next_prdata = ctrl;
				ffc_pkg::A_TGT:  next_prdata = {20'h00000, tgt};
				ffc_pkg::A_STAT: begin
					next_prdata[ffc_pkg::ST_BUSY]  = state != ffc_pkg::S_IDLE;
					next_prdata[ffc_pkg::ST_VALID] = pvalid;
					next_prdata[ffc_pkg::ST_AUTO+:12] = auto_tgt;
				end
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (wr && paddr == ffc_pkg::A_CTRL) begin
			next_ctrl = 32'h0000_0000;
			next_ctrl[ffc_pkg::CTRL_EN]   = pwdata[ffc_pkg::CTRL_EN];
			next_ctrl[ffc_pkg::CTRL_MAN]  = pwdata[ffc_pkg::CTRL_MAN];
			next_ctrl[ffc_pkg::CTRL_FMT8] = pwdata[ffc_pkg::CTRL_FMT8];
			next_ctrl[ffc_pkg::CTRL_SLOT+:ffc_pkg::SLOT_FW] =
				ffc_pkg::SLOT_FW'(pwdata[ffc_pkg::CTRL_SLOT+:SW]);
		end
		if (wr && paddr == ffc_pkg::A_TGT && pwdata[11:0] != 12'h000) begin
			next_tgt = pwdata[11:0];
		end
		case (state)
			ffc_pkg::S_IDLE: begin
				next_cnt    = '0;
				next_slot_l = ctrl[ffc_pkg::CTRL_SLOT+:SW];
				if (wr && paddr == ffc_pkg::A_CMD) begin
					if (pwdata[ffc_pkg::CMD_BUILD]) begin
						next_state = ffc_pkg::S_ARM;
					end else if (pwdata[ffc_pkg::CMD_STORE]) begin
						next_state = ffc_pkg::S_STORE;
					end else if (pwdata[ffc_pkg::CMD_FETCH]) begin
						next_state = ffc_pkg::S_FETCH;
					end
				end
			end
			ffc_pkg::S_ARM: begin
				next_acc = '0;
				next_tot = '0;
			end
			ffc_pkg::S_STORE: begin
				nvm_we   = 1'b1;
				next_cnt = cnt + 1'b1;
				if (cnt == PW'(NPTS - 1)) begin
					next_state = ffc_pkg::S_IDLE;
				end
			end
			ffc_pkg::S_FETCH: begin
				prof_we  = 1'b1;
				prof_wa  = cnt;
				prof_wd  = nvm[{slot_l, cnt}];
				next_cnt = cnt + 1'b1;
				if (cnt == PW'(NPTS - 1)) begin
					next_pvalid = 1'b1;
					next_state  = ffc_pkg::S_IDLE;
				end
			end
			default: ;
		endcase
		// Average each group of pixels of the first line into one point
		if (building && push) begin
			next_state  = ffc_pkg::S_BUILD;
			next_pvalid = 1'b0;
			next_acc    = (state == ffc_pkg::S_ARM ? '0 : acc) + (12+SH)'(in_pix.data);
			next_tot    = (state == ffc_pkg::S_ARM ? '0 : tot) + TW'(in_pix.data);
			if (f == SH'(DEC - 1)) begin
				prof_we  = 1'b1;
				prof_wd  = next_acc[11+SH:SH];
				next_acc = '0;
			end
			if (cur_col == CW'(LINE_W - 1)) begin
				next_auto_tgt = next_tot[TW-1:CW];
				next_pvalid   = 1'b1;
				next_state    = ffc_pkg::S_IDLE;
			end
		end
	end

	// Register control state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state    <= ffc_pkg::S_IDLE;
			ctrl     <= 32'h0000_0000;
			tgt      <= ffc_pkg::TGT_RST;
			auto_tgt <= ffc_pkg::TGT_RST;
			pvalid   <= 1'b0;
			cnt      <= '0;
			slot_l   <= '0;
			col      <= '0;
			acc      <= '0;
			tot      <= '0;
			prdata   <= 32'h0000_0000;
		end else begin
			state    <= next_state;
			ctrl     <= next_ctrl;
			tgt      <= next_tgt;
			auto_tgt <= next_auto_tgt;
			pvalid   <= next_pvalid;
			cnt      <= next_cnt;
			slot_l   <= next_slot_l;
			col      <= next_col;
			acc      <= next_acc;
			tot      <= next_tot;
			prdata   <= next_prdata;
		end
	end

	// Profile and slot memories
	always_ff @(posedge mclk) begin
		if (prof_we) begin
			prof[prof_wa] <= prof_wd;
		end
		if (nvm_we) begin
			nvm[{slot_l, cnt}] <= prof[cnt];
		end
	end

	// Two-entry output buffer absorbs receiver stalls
	ffc_pkg::ffc_pix_t fq [2];
	ffc_pkg::ffc_pix_t next_fq [2];
	logic       wp, rp, next_wp, next_rp;
	logic [1:0] fcnt, next_fcnt;

	assign in_ready  = fcnt != 2'd2;
	assign out_valid = fcnt != 2'd0;
	assign pop       = out_valid & out_ready;
	assign out_pix   = fq[rp];

	always_comb begin
		next_fq   = fq;
		next_wp   = wp;
		next_rp   = rp;
		next_fcnt = fcnt;
		if (push) begin
			next_fq[wp] = res;
			next_wp     = ~wp;
		end
		if (pop) begin
			next_rp = ~rp;
		end
		next_fcnt = fcnt + {1'b0, push} - {1'b0, pop};
	end

	// Register buffer state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fq[0] <= '0;
			fq[1] <= '0;
			wp    <= 1'b0;
			rp    <= 1'b0;
			fcnt  <= 2'd0;
		end else begin
			fq    <= next_fq;
			wp    <= next_wp;
			rp    <= next_rp;
			fcnt  <= next_fcnt;
		end
	end
endmodule
`default_nettype wire

// *** verif/ffc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffc_checker #(
	parameter int LINE_W = 512,
	parameter int DEC    = 16,
	parameter int SLOTS  = 16
) (
	input wire logic              mclk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              in_valid,
	input wire logic              in_ready,
	input wire ffc_pkg::ffc_pix_t in_pix,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire ffc_pkg::ffc_pix_t out_pix
);
	logic [2:0] ctrl_q;
	logic       acc;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	assign acc = psel && penable;
	// Shadow of the low control bits
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			ctrl_q <= 3'h0;
		else if (acc && pwrite && paddr == ffc_pkg::A_CTRL)
			ctrl_q <= pwdata[2:0];
	end
	AST_PREADY: assert property (acc |-> pready) else $error("access without ready");
	AST_UNMAP: assert property (acc && paddr > 8'h0c |-> pslverr) else $error("unmapped without error");
	AST_MAPPED: assert property (acc && paddr <= 8'h0c && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped with error");
	AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
		else $error("stalled beat changed");
	AST_FULL: assert property (!in_ready |-> out_valid) else $error("refused while empty");
	AST_RST: assert property ($rose(nrst) |-> !out_valid) else $error("beat after reset");
	AST_CMDRD: assert property (acc && !pwrite && paddr == ffc_pkg::A_CMD |-> prdata == 32'h0)
		else $error("command reads nonzero");
	AST_PASS: assert property (in_valid && in_ready && !out_valid && ctrl_q == 3'h0 |=> out_pix == $past(in_pix))
		else $error("pass-through altered");
	cover property (acc && pwrite && paddr == ffc_pkg::A_CMD && pwdata[0]);
	cover property (!in_ready);
	cover property (acc && pslverr);
endmodule
bind ffc_top ffc_checker #(.LINE_W(LINE_W), .DEC(DEC), .SLOTS(SLOTS)) i_ffc_checker (.mclk(mclk), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix),
	.out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));
`default_nettype wire

// *** verif/ffc_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffc_sink (
	input wire logic              mclk,
	input wire logic              out_valid,
	input wire ffc_pkg::ffc_pix_t out_pix,
	output logic                  out_ready
);
	ffc_pkg::ffc_pix_t q[$];
	logic [31:0]       s = 32'h5a5;
	initial out_ready = 1'b0;
	// Grabber takes beats, stalls at random
	always @(posedge mclk) begin
		if (out_valid && out_ready)
			q.push_back(out_pix);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		out_ready <= s[0] | s[1];
	end
endmodule
`default_nettype wire

// *** verif/ffc_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffc_tb_top;
	logic              mclk, nrst, psel, penable, pwrite, pready, pslverr;
	logic              in_valid, in_ready, out_valid, out_ready, en, man, f8;
	logic [7:0]        paddr;
	logic [4:0]        slot;
	logic [11:0]       tgt, prof, atgt, v1, v2;
	logic [31:0]       pwdata, prdata, rd, s;
	ffc_pkg::ffc_pix_t in_pix, out_pix, e_q[$];
	int                n_errors, num_checks;
	ffc_top #(.LINE_W(32), .DEC(4), .SLOTS(4)) i_ffc_top (.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_pix(in_pix),
		.out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));
	ffc_sink i_ffc_sink (.mclk(mclk), .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [11:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s[11:0];
	endfunction
	// Expected corrected level
	function automatic logic [11:0] fix(input logic [11:0] d);
		logic [31:0] v;
		v = {20'h0, d};
		if (en && prof != 12'h0)
			v = v * tgt / prof;
		if (v > 32'hfff)
			v = 32'hfff;
		if (f8)
			v = v >> 4;
		return v[11:0];
	endfunction
	task give_verdict();
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task tmo(input int k);
		if (k > 99) begin
			n_errors++;
			give_verdict();
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (k = 0; k < 100; k++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		tmo(k);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task idle();
		int k;
		for (k = 0; k < 100; k++) begin
			apb(1'b0, ffc_pkg::A_STAT, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		tmo(k);
	endtask
	task put(input logic f, input logic [11:0] d);
		int k;
		in_valid <= 1'b1;
		in_pix <= {f, f, d};
		e_q.push_back({f, f, fix(d)});
		for (k = 0; k < 100; k++) begin
			@(posedge mclk);
			if (in_ready === 1'b1)
				break;
		end
		tmo(k);
	endtask
	// One line in, then compare all beats out
	task line(input logic b, input logic [11:0] v);
		int c;
		for (c = 0; c < 32; c++)
			put(c == 0, b ? v : rnd());
		in_valid <= 1'b0;
		for (c = 0; c < 100 && i_ffc_sink.q.size() < e_q.size(); c++)
			@(negedge mclk);
		tmo(c);
		while (e_q.size() > 0)
			chk(32'(i_ffc_sink.q.pop_front()), 32'(e_q.pop_front()));
	endtask
	task cfg(input logic e, input logic m, input logic f, input logic [11:0] t);
		en = e;
		man = m;
		f8 = f;
		tgt = m ? t : atgt;
		apb(1'b1, ffc_pkg::A_CTRL, {23'h0, slot, 1'b0, f, m, e});
		if (m)
			apb(1'b1, ffc_pkg::A_TGT, {20'h0, t});
	endtask
	task build(input logic [11:0] v);
		cfg(1'b0, 1'b0, 1'b0, 12'h0);
		apb(1'b1, ffc_pkg::A_CMD, 32'h1);
		line(1'b1, v);
		idle();
		prof = v;
		atgt = v;
		apb(1'b0, ffc_pkg::A_STAT, 32'h0);
		chk(rd, {4'h0, v, 16'h2});
	endtask
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, in_valid, in_pix} = '0;
		{en, man, f8, slot, tgt, prof, n_errors, num_checks} = '0;
		s = 32'd35;
		atgt = 12'h800;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b0, ffc_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ffc_pkg::A_STAT, 32'h0);
		chk(rd, 32'h08000000);
		apb(1'b1, ffc_pkg::A_TGT, 32'h0);
		apb(1'b0, ffc_pkg::A_TGT, 32'h0);
		chk(rd, 32'h800);
		apb(1'b0, ffc_pkg::A_CMD, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		cfg(1'b1, 1'b0, 1'b0, 12'h0);
		line(1'b0, 12'h0);
		v1 = rnd() | 12'h100;
		v2 = rnd() | 12'h100;
		build(v1);
		slot = 5'h1;
		cfg(1'b0, 1'b0, 1'b0, 12'h0);
		apb(1'b1, ffc_pkg::A_CMD, 32'h2);
		apb(1'b1, ffc_pkg::A_CMD, 32'h1);
		idle();
		apb(1'b0, ffc_pkg::A_STAT, 32'h0);
		chk(rd, {4'h0, v1, 16'h2});
		build(v2);
		cfg(1'b1, 1'b0, 1'b0, 12'h0);
		line(1'b0, 12'h0);
		cfg(1'b1, 1'b1, 1'b0, rnd() | 12'h1);
		line(1'b0, 12'h0);
		cfg(1'b0, 1'b1, 1'b1, 12'hfff);
		line(1'b0, 12'h0);
		apb(1'b1, ffc_pkg::A_CMD, 32'h4);
		idle();
		prof = v1;
		cfg(1'b1, 1'b1, 1'b1, 12'hfff);
		line(1'b0, 12'h0);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b0, ffc_pkg::A_STAT, 32'h0);
		chk(rd, 32'h08000000);
		give_verdict();
	end
endmodule
`default_nettype wire
